/* rtl/cable_diag_pkg.sv */
// shared constants and types for the cable diagnostic control block
package cable_diag_pkg;
	// register word and address widths
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;

	// register offsets
	localparam logic [15:0] OFF_EQ_TIMER   = 16'h0126;
	localparam logic [15:0] OFF_DIAG_CTRL  = 16'h0155;
	localparam logic [15:0] OFF_MAIN_CTRL  = 16'h0170;
	localparam logic [15:0] OFF_PULSE_CTRL = 16'h0171;
	localparam logic [15:0] OFF_LISTEN     = 16'h0173;
	localparam logic [15:0] OFF_SHORT_THR  = 16'h0177;
	localparam logic [15:0] OFF_IRQ_STAT   = 16'h0190;
	localparam logic [15:0] OFF_IRQ_MASK   = 16'h0191;

	// field positions in the diagnostic control word
	localparam int POS_START   = 15;
	localparam int POS_BUSY    = 12;
	localparam int POS_SUM_LO  = 4;
	// field positions in the main control word
	localparam int POS_CROSS   = 14;
	localparam int POS_TX_BYP  = 13;
	localparam int POS_RX_BYP  = 12;
	localparam int POS_AVG_LO  = 8;
	// field positions in the other control words
	localparam int POS_REFL_LO = 0;
	localparam int POS_LIST_LO = 8;
	localparam int POS_THR_LO  = 8;

	// reset values
	localparam logic [15:0] RST_EQ_TIMER   = 16'h461B;
	localparam logic [3:0]  RST_DIAG_LOW   = 4'h1;
	localparam logic [7:0]  RST_SUM        = 8'hF4;
	localparam logic [15:0] RST_MAIN_CTRL  = 16'h0E52;
	localparam logic [15:0] RST_PULSE_CTRL = 16'hC85C;
	localparam logic [15:0] RST_LISTEN     = 16'hFF1E;
	localparam logic [15:0] RST_SHORT_THR  = 16'h189B;

	// writable bits per word; the rest read back as stored
	localparam logic [15:0] WMASK_MAIN     = 16'h7FFF;
	localparam logic [15:0] WMASK_FULL     = 16'hFFFF;

	// averaging code that is reserved, and the code it falls back to
	localparam logic [2:0]  AVG_RESERVED   = 3'h7;
	localparam logic [2:0]  AVG_FALLBACK   = 3'h6;

	// interrupt status bits
	localparam int IRQ_W        = 2;
	localparam int IRQ_DONE     = 0;
	localparam int IRQ_REFUSED  = 1;

	// diagnostic sequencer states
	typedef enum logic {st_idle, st_run} diag_state_t;

	// settings handed to the reflectometry engine
	typedef struct packed {
		logic       cross_enable;
		logic       run_tx;
		logic       run_rx;
		logic [6:0] avg_cycles;
		logic [3:0] self_refl;
		logic [7:0] listen_len;
		logic [4:0] short_thresh;
	} engine_cfg_t;
endpackage : cable_diag_pkg

/* rtl/cable_diagnostic_control.sv */
// register file and launch sequencer for the cable diagnostics
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module cable_diagnostic_control (
	input  wire logic                        mclk,
	input  wire logic                        nrst,
	input  wire logic [15:0]                 addr,
	input  wire logic [15:0]                 wr_data,
	input  wire logic                        wr_stb,
	input  wire logic                        rd_stb,
	output logic      [15:0]                 rd_data,
	output logic                             engine_start,
	output cable_diag_pkg::engine_cfg_t      engine_cfg,
	input  wire logic                        engine_done,
	input  wire logic [7:0]                  active_diag_sum_result,
	output logic                             irq
);

	// address compare shared by read and write decoding
	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == off);
	endfunction : hit

	// masked write: only bits set in m take the new value
	function automatic logic [15:0] merge(
		input logic [15:0] old_v,
		input logic [15:0] new_v,
		input logic [15:0] m
	);
		merge = (old_v & ~m) | (new_v & m);
	endfunction : merge

	// register write strobes, one per word
	logic wr_eq;       // equalizer timer word
	logic wr_diag;     // diagnostic control word
	logic wr_main;     // main control word
	logic wr_pulse;    // pulse control word
	logic wr_listen;   // listen length word
	logic wr_thr;      // short cable threshold word
	logic wr_istat;    // interrupt status
	logic wr_imask;    // interrupt mask

	// write decode, unmapped writes fall through to nothing
	always_comb
	begin
		wr_eq     = wr_stb && hit(addr, cable_diag_pkg::OFF_EQ_TIMER);
		wr_diag   = wr_stb && hit(addr, cable_diag_pkg::OFF_DIAG_CTRL);
		wr_main   = wr_stb && hit(addr, cable_diag_pkg::OFF_MAIN_CTRL);
		wr_pulse  = wr_stb && hit(addr, cable_diag_pkg::OFF_PULSE_CTRL);
		wr_listen = wr_stb && hit(addr, cable_diag_pkg::OFF_LISTEN);
		wr_thr    = wr_stb && hit(addr, cable_diag_pkg::OFF_SHORT_THR);
		wr_istat  = wr_stb && hit(addr, cable_diag_pkg::OFF_IRQ_STAT);
		wr_imask  = wr_stb && hit(addr, cable_diag_pkg::OFF_IRQ_MASK);
	end

	// configuration words, held whole so reserved bits read back
	logic [15:0] eq_ff;       // equalizer timer, no effect here
	logic [15:0] main_ff;     // cross, bypass and averaging
	logic [15:0] pulse_ff;    // expected self-reflection
	logic [15:0] listen_ff;   // listen duration
	logic [15:0] thr_ff;      // short cable threshold
	logic [3:0]  dlow_ff;     // reserved low bits of diag word
	logic [15:0] nxt_eq;
	logic [15:0] nxt_main;
	logic [15:0] nxt_pulse;
	logic [15:0] nxt_listen;
	logic [15:0] nxt_thr;
	logic [3:0]  nxt_dlow;

	// next values of the configuration words
	always_comb
	begin
		nxt_eq     = eq_ff;
		nxt_main   = main_ff;
		nxt_pulse  = pulse_ff;
		nxt_listen = listen_ff;
		nxt_thr    = thr_ff;
		nxt_dlow   = dlow_ff;
		// bit 15 of the main word is read-only zero
		if (wr_main)
			nxt_main = merge(main_ff, wr_data, cable_diag_pkg::WMASK_MAIN);
		if (wr_eq)
			nxt_eq = merge(eq_ff, wr_data, cable_diag_pkg::WMASK_FULL);
		if (wr_pulse)
			nxt_pulse = wr_data;
		if (wr_listen)
			nxt_listen = wr_data;
		if (wr_thr)
			nxt_thr = wr_data;
		if (wr_diag)
			nxt_dlow = wr_data[3:0];
	end

	// configuration registers with their reset values
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			eq_ff     <= cable_diag_pkg::RST_EQ_TIMER;
			main_ff   <= cable_diag_pkg::RST_MAIN_CTRL;
			pulse_ff  <= cable_diag_pkg::RST_PULSE_CTRL;
			listen_ff <= cable_diag_pkg::RST_LISTEN;
			thr_ff    <= cable_diag_pkg::RST_SHORT_THR;
			dlow_ff   <= cable_diag_pkg::RST_DIAG_LOW;
		end
		else
		begin
			eq_ff     <= nxt_eq;
			main_ff   <= nxt_main;
			pulse_ff  <= nxt_pulse;
			listen_ff <= nxt_listen;
			thr_ff    <= nxt_thr;
			dlow_ff   <= nxt_dlow;
		end
	end

	// averaging code, the reserved code is run as the largest count
	logic [2:0] avg_code;
	always_comb
	begin
		avg_code = main_ff[cable_diag_pkg::POS_AVG_LO +: 3];
		if (avg_code == cable_diag_pkg::AVG_RESERVED)
			avg_code = cable_diag_pkg::AVG_FALLBACK;
	end

	// engine settings; a bypass bit of one removes that pair
	always_comb
	begin
		engine_cfg.cross_enable = !main_ff[cable_diag_pkg::POS_CROSS];
		engine_cfg.run_tx       = !main_ff[cable_diag_pkg::POS_TX_BYP];
		engine_cfg.run_rx       = !main_ff[cable_diag_pkg::POS_RX_BYP];
		engine_cfg.avg_cycles   = 7'h01 << avg_code;
		engine_cfg.self_refl    = pulse_ff[cable_diag_pkg::POS_REFL_LO +: 4];
		engine_cfg.listen_len   = listen_ff[cable_diag_pkg::POS_LIST_LO +: 8];
		engine_cfg.short_thresh = thr_ff[cable_diag_pkg::POS_THR_LO +: 5];
	end

	// launch sequencer state
	cable_diag_pkg::diag_state_t state_ff;
	cable_diag_pkg::diag_state_t nxt_state;
	logic       busy_ff;     // status bit, one until done
	logic       start_ff;    // one-cycle launch pulse
	logic [7:0] sum_ff;      // result captured on completion
	logic       nxt_busy;
	logic       nxt_start;
	logic [7:0] nxt_sum;
	logic       launch_req;  // software asked for a run
	logic       ev_done;     // run completed this cycle
	logic       ev_refused;  // launch asked while already running

	// sequencer next state; a launch while running is refused
	always_comb
	begin
		nxt_state  = state_ff;
		nxt_busy   = busy_ff;
		nxt_start  = 1'b0;
		nxt_sum    = sum_ff;
		ev_done    = 1'b0;
		ev_refused = 1'b0;
		launch_req = wr_diag && wr_data[cable_diag_pkg::POS_START];
		case (state_ff)
			cable_diag_pkg::st_idle:
			begin
				// a written zero launches nothing
				if (launch_req)
				begin
					nxt_state = cable_diag_pkg::st_run;
					nxt_start = 1'b1;
					nxt_busy  = 1'b1;
				end
			end
			cable_diag_pkg::st_run:
			begin
				// the engine reports the end with a single pulse
				if (engine_done)
				begin
					nxt_state = cable_diag_pkg::st_idle;
					nxt_busy  = 1'b0;
					nxt_sum   = active_diag_sum_result;
					ev_done   = 1'b1;
				end
				// relaunching mid-run would corrupt the averages
				if (launch_req)
					ev_refused = 1'b1;
			end
			default:
				nxt_state = cable_diag_pkg::st_idle;
		endcase
	end

	// sequencer registers; status reads one out of reset
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_ff <= cable_diag_pkg::st_idle;
			busy_ff  <= 1'b1;
			start_ff <= 1'b0;
			sum_ff   <= cable_diag_pkg::RST_SUM;
		end
		else
		begin
			state_ff <= nxt_state;
			busy_ff  <= nxt_busy;
			start_ff <= nxt_start;
			sum_ff   <= nxt_sum;
		end
	end

	// launch goes to the engine; start bit itself is never stored
	assign engine_start = start_ff;

	// interrupt status and mask
	logic [1:0] istat_ff;    // sticky events
	logic [1:0] imask_ff;    // one lets the event through
	logic [1:0] nxt_istat;
	logic [1:0] nxt_imask;
	logic [1:0] ev_vec;

	// write one clears; a same-cycle event wins over the clear
	always_comb
	begin
		ev_vec = '0;
		ev_vec[cable_diag_pkg::IRQ_DONE]    = ev_done;
		ev_vec[cable_diag_pkg::IRQ_REFUSED] = ev_refused;
		nxt_istat = istat_ff;
		nxt_imask = imask_ff;
		if (wr_istat)
			nxt_istat = istat_ff & ~wr_data[1:0];
		nxt_istat = nxt_istat | ev_vec;
		if (wr_imask)
			nxt_imask = wr_data[1:0];
	end

	// interrupt registers, all masked off after reset
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			istat_ff <= '0;
			imask_ff <= '0;
		end
		else
		begin
			istat_ff <= nxt_istat;
			imask_ff <= nxt_imask;
		end
	end

	// level interrupt while any unmasked event is pending
	assign irq = |(istat_ff & imask_ff);

	// read data, valid only in the cycle after the strobe
	logic [15:0] rd_ff;
	logic [15:0] nxt_rd;
	logic [15:0] diag_word;

	// diag word: start reads zero, bits 14:13 reserved zero
	always_comb
	begin
		diag_word = {12'h000, dlow_ff};
		diag_word[cable_diag_pkg::POS_BUSY] = busy_ff;
		diag_word[cable_diag_pkg::POS_SUM_LO +: 8] = sum_ff;
	end

	// read mux, unmapped addresses return zero
	always_comb
	begin
		nxt_rd = '0;
		if (!rd_stb)
			nxt_rd = '0;
		else if (hit(addr, cable_diag_pkg::OFF_EQ_TIMER))
			nxt_rd = eq_ff;
		else if (hit(addr, cable_diag_pkg::OFF_DIAG_CTRL))
			nxt_rd = diag_word;
		else if (hit(addr, cable_diag_pkg::OFF_MAIN_CTRL))
			nxt_rd = main_ff;
		else if (hit(addr, cable_diag_pkg::OFF_PULSE_CTRL))
			nxt_rd = pulse_ff;
		else if (hit(addr, cable_diag_pkg::OFF_LISTEN))
			nxt_rd = listen_ff;
		else if (hit(addr, cable_diag_pkg::OFF_SHORT_THR))
			nxt_rd = thr_ff;
		else if (hit(addr, cable_diag_pkg::OFF_IRQ_STAT))
			nxt_rd = {14'h0000, istat_ff};
		else if (hit(addr, cable_diag_pkg::OFF_IRQ_MASK))
			nxt_rd = {14'h0000, imask_ff};
	end

	// read data register
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			rd_ff <= '0;
		else
			rd_ff <= nxt_rd;
	end

	assign rd_data = rd_ff;

	// checks on the sequencer and configuration paths
	default clocking chk_clk @(posedge mclk); endclocking
	default disable iff (!nrst);

	// a start write seen while idle
	sequence seq_launch;
		wr_stb && hit(addr, cable_diag_pkg::OFF_DIAG_CTRL)
			&& wr_data[cable_diag_pkg::POS_START] && state_ff == cable_diag_pkg::st_idle;
	endsequence

	// the run ends with the engine done pulse
	sequence seq_finish;
		state_ff == cable_diag_pkg::st_run && engine_done;
	endsequence

	chk_launch_pulse: assert property (seq_launch |=> engine_start ##1 !engine_start)
		else $error("launch did not give a single start pulse");

	chk_zero_no_launch: assert property (
		wr_diag && !wr_data[cable_diag_pkg::POS_START] |=> !engine_start)
		else $error("writing zero launched the engine");

	chk_busy_read: assert property (
		rd_stb && hit(addr, cable_diag_pkg::OFF_DIAG_CTRL) && state_ff == cable_diag_pkg::st_run
		|=> rd_data[cable_diag_pkg::POS_BUSY])
		else $error("status did not read busy during a run");

	chk_done_clears: assert property (seq_finish |=> !busy_ff
		&& istat_ff[cable_diag_pkg::IRQ_DONE] && (irq || !imask_ff[cable_diag_pkg::IRQ_DONE]))
		else $error("completion did not clear status or raise interrupt");

	chk_cross_mode: assert property (
		wr_main |=> engine_cfg.cross_enable == !$past(wr_data[cable_diag_pkg::POS_CROSS]))
		else $error("cross mode does not follow its bit");

	chk_tx_bypass: assert property (
		wr_main |=> engine_cfg.run_tx == !$past(wr_data[cable_diag_pkg::POS_TX_BYP]))
		else $error("transmit pair bypass does not follow its bit");

	chk_rx_bypass: assert property (
		wr_main |=> engine_cfg.run_rx == !$past(wr_data[cable_diag_pkg::POS_RX_BYP]))
		else $error("receive pair bypass does not follow its bit");

	chk_avg_count: assert property (
		wr_main && wr_data[10:8] != 3'h7 |=> engine_cfg.avg_cycles == 7'h01 << $past(wr_data[10:8]))
		else $error("averaging count does not match its code");

	chk_refl_level: assert property (wr_pulse |=> engine_cfg.self_refl == $past(wr_data[3:0]))
		else $error("self-reflection level not taken");

	chk_listen_len: assert property (
		wr_listen |=> engine_cfg.listen_len == $past(wr_data[15:8]))
		else $error("listen length not taken");

	chk_short_thr: assert property (
		wr_thr |=> engine_cfg.short_thresh == $past(wr_data[12:8]))
		else $error("short cable threshold not taken");

endmodule : cable_diagnostic_control

/* test/cable_diagnostic_control_bench.sv */
// self-checking bench for the cable diagnostic control block
`timescale 1ns/1ps
module cable_diagnostic_control_bench;
	logic                        mclk;         // 10 MHz clock
	logic                        nrst;         // active low reset
	logic [15:0]                 addr;         // register address
	logic [15:0]                 wr_data;      // write data
	logic                        wr_stb;       // write strobe
	logic                        rd_stb;       // read strobe
	logic [15:0]                 rd_data;      // read data
	logic                        engine_start; // launch pulse
	cable_diag_pkg::engine_cfg_t engine_cfg;   // engine settings
	cable_diag_pkg::engine_cfg_t exp_cfg;      // expected settings
	logic                        engine_done;  // run end from the model
	logic [7:0]                  sum_bus;      // result from the model
	logic [7:0]                  done_delay;   // model latency
	logic [7:0]                  sum_value;    // model result value
	logic                        irq;          // interrupt line
	logic [15:0]                 v;            // last read value
	logic [2:0]                  code;         // loop code
	int                          n_mismatch;
	int                          checked;

	cable_diagnostic_control uut (.mclk(mclk), .nrst(nrst), .addr(addr),
		.wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
		.engine_start(engine_start), .engine_cfg(engine_cfg),
		.engine_done(engine_done), .active_diag_sum_result(sum_bus), .irq(irq));

	refl_engine_model engine (.mclk(mclk), .nrst(nrst), .engine_start(engine_start),
		.done_delay(done_delay), .sum_value(sum_value), .engine_done(engine_done),
		.sum_out(sum_bus));

	// free running clock
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// verdict and end of run
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	// one cycle write strobe
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk);
		wr_stb  <= 1'b1;
		addr    <= a;
		wr_data <= d;
		@(posedge mclk);
		wr_stb  <= 1'b0;
		#1;
	endtask : wr

	// one cycle read strobe; data taken in the following cycle only
	task rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge mclk);
		rd_stb <= 1'b1;
		addr   <= a;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1;
		d = rd_data;
	endtask : rd

	// poll the busy bit with a bound; a hang ends the run
	task wait_idle;
		for (int i = 0; i < 100; i++)
		begin
			rd(16'h0155, v);
			if (v[12] === 1'b0)
				return;
		end
		n_mismatch++;
		tally_and_finish();
	endtask : wait_idle

	// launch and check the one cycle start pulse
	task launch;
		wr(16'h0155, 16'h8000);
		chk(engine_start, 1'b1);
		@(posedge mclk);
		#1;
		chk(engine_start, 1'b0);
	endtask : launch

	// reset words plus unmapped places
	localparam logic [15:0] RA [10] = '{16'h0126, 16'h0155, 16'h0170, 16'h0171,
		16'h0173, 16'h0177, 16'h0190, 16'h0191, 16'h0172, 16'h0200};
	localparam logic [15:0] RV [10] = '{16'h461B, 16'h1F41, 16'h0E52, 16'hC85C,
		16'hFF1E, 16'h189B, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

	// main sequence
	initial
	begin
		n_mismatch = 0;
		checked    = 0;
		nrst       = 1'b0;
		addr       = 16'h0000;
		wr_data    = 16'h0000;
		wr_stb     = 1'b0;
		rd_stb     = 1'b0;
		done_delay = 8'h14;
		sum_value  = 8'h3C;
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		#1;
		exp_cfg = '{1'b1, 1'b1, 1'b1, 7'h40, 4'hC, 8'hFF, 5'h18};
		chk(engine_cfg, exp_cfg);
		chk(irq, 1'b0);
		// reset values and unmapped reads
		for (int i = 0; i < 10; i++)
		begin
			rd(RA[i], v);
			chk(v, RV[i]);
		end
		// every mode bit and averaging code, bit 15 of the main word never stored
		for (int k = 0; k < 8; k++)
		begin
			code = 3'(k);
			wr(16'h0170, {1'b1, code, 1'b0, code, 8'h00});
			exp_cfg.cross_enable = ~code[2];
			exp_cfg.run_tx       = ~code[1];
			exp_cfg.run_rx       = ~code[0];
			exp_cfg.avg_cycles   = (code == 3'h7) ? 7'h40 : (7'h01 << code);
			chk(engine_cfg, exp_cfg);
			rd(16'h0170, v);
			chk(v, {4'h0 | code, 1'b0, code, 8'h00});
		end
		// other fields, with bits set outside each field
		wr(16'h0171, 16'h5A53);
		wr(16'h0173, 16'h00A5);
		wr(16'h0177, 16'hE7C4);
		exp_cfg.self_refl    = 4'h3;
		exp_cfg.listen_len   = 8'h00;
		exp_cfg.short_thresh = 5'h07;
		chk(engine_cfg, exp_cfg);
		rd(16'h0177, v);
		chk(v, 16'hE7C4);
		// slow run, second launch refused while running, interrupt masked
		launch();
		rd(16'h0155, v);
		chk(v, 16'h1F40);
		wr(16'h0155, 16'h8000);
		chk(engine_start, 1'b0);
		wait_idle();
		chk(v, 16'h03C0);
		rd(16'h0190, v);
		chk(v, 16'h0003);
		chk(irq, 1'b0);
		wr(16'h0191, 16'h0001);
		chk(irq, 1'b1);
		wr(16'h0190, 16'h0003);
		chk(irq, 1'b0);
		rd(16'h0190, v);
		chk(v, 16'h0000);
		// zero in the start bit launches nothing
		wr(16'h0155, 16'h000A);
		chk(engine_start, 1'b0);
		rd(16'h0155, v);
		chk(v, 16'h03CA);
		// prompt run with the interrupt unmasked
		done_delay <= 8'h00;
		sum_value  <= 8'hC5;
		launch();
		wait_idle();
		chk(v, 16'h0C50);
		@(posedge mclk);
		#1;
		chk(irq, 1'b1);
		wr(16'h0190, 16'h0001);
		chk(irq, 1'b0);
		tally_and_finish();
	end
endmodule : cable_diagnostic_control_bench

/* test/refl_engine_model.sv */
// behavioural reflectometry engine standing on the far side of the block
`timescale 1ns/1ps
module refl_engine_model (
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic       engine_start,
	input  wire logic [7:0] done_delay,
	input  wire logic [7:0] sum_value,
	output logic            engine_done,
	output logic      [7:0] sum_out
);
	logic       run_ff;   // a run is in progress
	logic [7:0] cnt_ff;   // cycles left until the run ends

	// count down the chosen delay, then pulse done once
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			run_ff      <= 1'b0;
			cnt_ff      <= 8'h00;
			engine_done <= 1'b0;
		end
		else
		begin
			engine_done <= 1'b0;
			if (engine_start && !run_ff)
			begin
				run_ff <= 1'b1;
				cnt_ff <= done_delay;
			end
			else if (run_ff && cnt_ff == 8'h00)
			begin
				run_ff      <= 1'b0;
				engine_done <= 1'b1;
			end
			else if (run_ff)
				cnt_ff <= cnt_ff - 8'h01;
		end
	end

	// result only valid beside done; otherwise inverted so stale data never passes
	assign sum_out = engine_done ? sum_value : ~sum_value;
endmodule : refl_engine_model
